/* sim/ufs_remote.sv */
`timescale 1ns/1ns
`default_nettype none
module ufs_remote #(
  parameter int D = 4
) (
  // clock
  input  wire logic clk,
  // serial line
  input  wire logic txd,
  output logic      rxd,
  // flow control
  input  wire logic ready,
  output logic      ctsN
);
  logic [7:0] got [$];
  logic [7:0] sh;
  assign ctsN = ~ready;
  initial rxd = 1'b1;
  // ==========================================================
  // receiver
  // frames ending low are dropped, so an aborted character never counts
  always begin
    @(negedge txd);
    repeat (D / 2 + D) @(posedge clk);
    repeat (8) begin
      sh = {txd, sh[7:1]};
      repeat (D) @(posedge clk);
    end
    if (txd) got.push_back(sh);
  end
  // ==========================================================
  // sender
  task automatic send(input logic [7:0] v, input logic stopBit);
    logic [9:0] f;
    f = {stopBit, v, 1'b0};
    repeat (10) begin
      @(posedge clk);
      rxd <= f[0];
      f = f >> 1;
      repeat (D - 1) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1;
    repeat (2 * D) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* sim/ufs_uart_core_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin nTests++; if ((s) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module ufs_uart_core_bench;
  // ==========================================================
  // stimulus and model state
  logic        clk = 1'b0;
  logic        rstN = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        ready = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, ex;
  logic        pready, pslverr, err, rxd, txd, ctsN, rtsN;
  logic [7:0]  b;
  logic [7:0]  txQ [$];
  logic [7:0]  rxQ [$];
  int          errors = 0;
  int          nTests = 0;
  int          seed = 32'h0dee9d40;
  always #10 clk = ~clk;
  ufs_uart_core u_ufs_uart_core (.clk(clk), .rst_n(rstN), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .cts_n(ctsN), .rts_n(rtsN));
  ufs_remote #(.D(4)) u_ufs_remote (.clk(clk), .txd(txd), .rxd(rxd), .ready(ready),
    .ctsN(ctsN));
  // ==========================================================
  // bus and model tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic put();
    b = 8'($random(seed));
    txQ.push_back(b);
    apb(1'b1, ufs_pkg::A_DATA, {24'h0, b});
  endtask
  task automatic checkTx();
    while (u_ufs_remote.got.size() < txQ.size()) @(posedge clk);
    // stop bit and trailing bit time pass before the shifter reads idle
    repeat (12) @(posedge clk);
    while (txQ.size() > 0) begin
      ex = {24'h0, txQ.pop_front()};
      b = u_ufs_remote.got.pop_front();
      `CHK("txByte", ex, {24'h0, b})
    end
    apb(1'b0, ufs_pkg::A_LSR, 32'h0);
    `CHK("txIdle", 32'h60, rd)
  endtask
  task automatic recv(input int n);
    repeat (n) begin
      b = 8'($random(seed));
      rxQ.push_back(b);
      u_ufs_remote.send(b, 1'b1);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    repeat (4) @(posedge clk);
    rstN <= 1'b1;
    apb(1'b0, ufs_pkg::A_LSR, 32'h0);
    `CHK("lsrReset", 32'h60, rd)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("badAddr", 1'b1, err)
    apb(1'b1, ufs_pkg::A_BAUD, 32'h4);
    apb(1'b1, ufs_pkg::A_CTRL, 32'h2);
    apb(1'b0, ufs_pkg::A_MSR, 32'h0);
    `CHK("ctsLevel", 1'b1, rd[4])
    repeat (3) put();
    apb(1'b0, ufs_pkg::A_LEVEL, 32'h0);
    `CHK("txLevel", 32'h300, rd)
    `CHK("ctsHold", 1'b1, txd)
    ready <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, ufs_pkg::A_MSR, 32'h0);
    `CHK("ctsChange", 32'h1, rd)
    checkTx();
    apb(1'b1, ufs_pkg::A_CTRL, 32'h0);
    ready <= 1'b0;
    put();
    checkTx();
    // second byte waits in the fifo and is flushed; the first keeps shifting
    put();
    put();
    apb(1'b1, ufs_pkg::A_FLUSH, 32'h1);
    void'(txQ.pop_back());
    checkTx();
    $display("flow control test done");
    // first byte is in the shifter when break lands and is lost
    apb(1'b1, ufs_pkg::A_DATA, 32'h5a);
    put();
    apb(1'b1, ufs_pkg::A_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("breakLow", 1'b0, txd)
    repeat (60) @(posedge clk);
    apb(1'b1, ufs_pkg::A_CTRL, 32'h0);
    checkTx();
    $display("break test done");
    recv(3);
    apb(1'b0, ufs_pkg::A_LEVEL, 32'h0);
    `CHK("rxLevel", 32'h3, rd)
    apb(1'b0, ufs_pkg::A_LSR, 32'h0);
    `CHK("dataReady", 1'b1, rd[0])
    while (rxQ.size() > 0) begin
      apb(1'b0, ufs_pkg::A_DATA, 32'h0);
      ex = {24'h0, rxQ.pop_front()};
      `CHK("rxByte", ex, {24'h0, rd[7:0]})
    end
    u_ufs_remote.send(8'h01, 1'b0);
    apb(1'b0, ufs_pkg::A_LSR, 32'h0);
    `CHK("frameErr", 32'h88, rd & 32'h88)
    apb(1'b0, ufs_pkg::A_LSR, 32'h0);
    `CHK("lsrClear", 32'h0, rd & 32'h9e)
    u_ufs_remote.send(8'h00, 1'b0);
    apb(1'b0, ufs_pkg::A_LSR, 32'h0);
    `CHK("breakIn", 32'h90, rd & 32'h90)
    // odd parity on; the stop argument lands in the parity slot
    apb(1'b1, ufs_pkg::A_CTRL, 32'h8);
    u_ufs_remote.send(8'h01, 1'b1);
    apb(1'b0, ufs_pkg::A_LSR, 32'h0);
    `CHK("parityErr", 32'h84, rd & 32'h8c)
    $display("receive test done");
    apb(1'b1, ufs_pkg::A_FLUSH, 32'h2);
    apb(1'b1, ufs_pkg::A_IER, 32'hf);
    apb(1'b1, ufs_pkg::A_CTRL, 32'h64);
    recv(17);
    apb(1'b0, ufs_pkg::A_LEVEL, 32'h0);
    `CHK("rxFull", 32'h10, rd)
    `CHK("rtsOff", 1'b1, rtsN)
    apb(1'b0, ufs_pkg::A_IIR, 32'h0);
    `CHK("iirLine", 4'h6, rd[3:0])
    apb(1'b0, ufs_pkg::A_LSR, 32'h0);
    `CHK("overrun", 1'b1, rd[1])
    apb(1'b0, ufs_pkg::A_IIR, 32'h0);
    `CHK("iirData", 4'h4, rd[3:0])
    apb(1'b1, ufs_pkg::A_FLUSH, 32'h3);
    apb(1'b0, ufs_pkg::A_LEVEL, 32'h0);
    `CHK("flushed", 32'h0, rd)
    `CHK("rtsOn", 1'b0, rtsN)
    apb(1'b0, ufs_pkg::A_CTRL, 32'h0);
    `CHK("trigReset", 2'h0, rd[6:5])
    $display("overrun test done");
    summarize();
  end
  // hang guard, well beyond the few thousand cycles the tests need
  initial begin
    #400000;
    errors++;
    summarize();
  end
endmodule
`default_nettype wire

/* verilog/ufs_pkg.sv */
package ufs_pkg;
  // ==========================================================
  // timing
  localparam int          CLK_HZ       = 50_000_000;
  localparam int          BAUD_DEFAULT = 115_200;
  localparam logic [15:0] DIV_RESET    = 16'(CLK_HZ / BAUD_DEFAULT);
  localparam logic [7:0]  TIMEOUT_BITS = 8'h28;
  // ==========================================================
  // fifo
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] RX_TRIG [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
  localparam logic [4:0] RTS_LVL [4] = '{5'h08, 5'h0b, 5'h0d, 5'h0f};
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] A_DATA  = 8'h00;
  localparam logic [7:0] A_CTRL  = 8'h04;
  localparam logic [7:0] A_FLUSH = 8'h08;
  localparam logic [7:0] A_LSR   = 8'h0c;
  localparam logic [7:0] A_MSR   = 8'h10;
  localparam logic [7:0] A_IIR   = 8'h14;
  localparam logic [7:0] A_LEVEL = 8'h18;
  localparam logic [7:0] A_IER   = 8'h1c;
  localparam logic [7:0] A_BAUD  = 8'h20;
  // ==========================================================
  // control fields
  localparam int C_BREAK = 0;
  localparam int C_ACTS  = 1;
  localparam int C_ARTS  = 2;
  localparam int C_PAREN = 3;
  localparam int C_EVEN  = 4;
  localparam int C_TRIG  = 5;
  localparam int C_RLVL  = 7;
  localparam int C_RTS   = 9;
  localparam logic [9:0] CTRL_RESET = 10'h000;
  localparam int F_TX = 0;
  localparam int F_RX = 1;
  localparam int IE_RXDATA = 0;
  localparam int IE_TX     = 1;
  localparam int IE_LINE   = 2;
  localparam int IE_MODEM  = 3;
  // ==========================================================
  // status fields
  localparam int LS_DR   = 0;
  localparam int LS_OE   = 1;
  localparam int LS_PE   = 2;
  localparam int LS_FE   = 3;
  localparam int LS_BI   = 4;
  localparam int LS_THRE = 5;
  localparam int LS_TEMT = 6;
  localparam int LS_ERR  = 7;
  localparam logic [7:0] LS_CLEAR_MASK = 8'h9e;
  localparam int MS_DCTS = 0;
  localparam int MS_CTS  = 4;
  localparam logic [2:0] IRQ_ID_RX_LINE_STATUS    = 3'h3;
  localparam logic [2:0] IRQ_ID_RX_DATA_AVAILABLE = 3'h2;
  localparam logic [2:0] IRQ_ID_CHAR_TIMEOUT      = 3'h6;
  localparam logic [2:0] IRQ_ID_TX_FIFO_EMPTY     = 3'h1;
  localparam logic [2:0] IRQ_ID_MODEM_STATUS      = 3'h0;
  // ==========================================================
  // states
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
    TX_PAR  = 3'b011, TX_STOP  = 3'b100, TX_END  = 3'b101
  } ufs_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
    RX_PAR  = 3'b011, RX_STOP  = 3'b100, RX_HOLD = 3'b101
  } ufs_rx_e;
endpackage

/* verilog/ufs_uart_core.sv */
// What this block does
// - break forces the line low, aborting the current character, until released
// - on break release transmission resumes with the fifo contents in order
// - tx and rx fifos flush separately or together; shifters are untouched
// - any flush returns the receive trigger level to one character
// - rx and tx fifo occupancy are readable as character counts
// - line status read clears error summary, break, framing, parity, overrun
// - error summary sets on parity error, framing error or break
// - shifter-empty flag is set while the tx shift register is idle
// - tx-fifo-empty flag is set while the tx fifo holds nothing
// - break flag sets when rx line stays low for a whole frame
// - framing error on bad stop bit, parity error on parity mismatch
// - overrun sets when a character completes while the rx fifo is full
// - data-ready flag is set while the rx fifo holds a character
// - modem status bit 4 shows the current cts level
// - modem status bit 0 shows that cts changed level
// - interrupt id reports only the highest priority pending source
// - interrupt id bit 0 is zero while another source remains pending
// - id codes by priority: line 3, data 2, timeout 6, tx 1, modem 0
// - a written byte starts sending once it reaches the fifo head
// - without auto cts, data is sent regardless of cts
// - with auto cts, sending starts only while cts is asserted
// - reading the data port pops one rx byte; empty reads are undefined
// - receive trigger level selects 1, 4, 8 or 14 characters
// - auto rts deasserts at 8, 11, 13 or 15 characters, reasserts below
`timescale 1ns/1ns
`default_nettype none

module ufs_fifo (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       flush,
  input  wire logic       push,
  input  wire logic [7:0] wrData,
  input  wire logic       pop,
  // status
  output logic      [7:0] rdData,
  output logic      [4:0] count
);
  logic [7:0] mem [16];
  logic [3:0] wrPtr;
  logic [3:0] rdPtr;
  logic [3:0] next_wrPtr;
  logic [3:0] next_rdPtr;
  logic [4:0] next_count;
  logic       doPush;
  logic       doPop;

  always_comb begin
    doPush     = push && count != ufs_pkg::FIFO_DEPTH && !flush;
    doPop      = pop && count != 5'h00 && !flush;
    next_wrPtr = wrPtr + 4'(doPush);
    next_rdPtr = rdPtr + 4'(doPop);
    next_count = count + 5'(doPush) - 5'(doPop);
    if (flush) begin
      next_wrPtr = 4'h0;
      next_rdPtr = 4'h0;
      next_count = 5'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= 4'h0;
      rdPtr <= 4'h0;
      count <= 5'h00;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr] <= wrData;
    end
  end

  assign rdData = mem[rdPtr];
endmodule

module ufs_uart_core (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial line
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic        cts_n,
  output logic             rts_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // synchronisers and bit-rate divider
  logic        rxdMeta, rxdSync, ctsMeta, ctsSync, ctsLast;
  logic [15:0] baudDiv, divCnt;
  logic        bitTick;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {rxdMeta, rxdSync, ctsMeta, ctsSync, ctsLast} <= 5'h1f;
      divCnt <= 16'h0000;
    end else begin
      {rxdMeta, rxdSync} <= {rxd, rxdMeta};
      {ctsMeta, ctsSync} <= {cts_n, ctsMeta};
      ctsLast            <= ctsSync;
      divCnt             <= bitTick ? baudDiv - 16'h0001 : divCnt - 16'h0001;
    end
  end
  assign bitTick = divCnt == 16'h0000;

  // ==========================================================
  // registers and fifos
  logic [9:0]  ctrl;
  logic [3:0]  ier;
  logic [7:0]  lsrSticky, lsrMask;
  logic        ctsChanged, msMask;
  logic [7:0]  txHead, rxHead, rxShift;
  logic [4:0]  txCount, rxCount, rxTrig;
  logic        txPush, txPop, rxPush, txFlush, rxFlush;
  logic        ctsOn, txEmpty, txShiftEmpty, timeoutP;
  logic [7:0]  lsrVal, msrVal, rxEv;
  logic        setOe, setPe, setFe, setBi;
  logic        setup, rdAccess, wrAccess, addrOk;
  ufs_pkg::ufs_tx_e txState;
  ufs_pkg::ufs_rx_e rxState;

  ufs_fifo txFifo (
    .clk(clk), .rst_n(rst_n), .flush(txFlush), .push(txPush),
    .wrData(pwdata[7:0]), .pop(txPop), .rdData(txHead), .count(txCount)
  );
  ufs_fifo rxFifo (
    .clk(clk), .rst_n(rst_n), .flush(rxFlush), .push(rxPush),
    .wrData(rxShift), .pop(rdAccess && paddr == ufs_pkg::A_DATA),
    .rdData(rxHead), .count(rxCount)
  );

  assign ctsOn        = !ctsSync;
  assign txEmpty      = txCount == 5'h00;
  assign txShiftEmpty = txState == ufs_pkg::TX_IDLE;
  assign rxTrig       = ufs_pkg::RX_TRIG[ctrl[ufs_pkg::C_TRIG +: 2]];
  assign lsrVal       = lsrSticky | {1'b0, txShiftEmpty, txEmpty, 4'h0,
                                     rxCount != 5'h00};
  assign msrVal       = {3'h0, ctsSync, 3'h0, ctsChanged};

  // ==========================================================
  // interrupt identification
  logic [4:0] pend;
  logic [2:0] iirId;
  logic [2:0] nPend;
  always_comb begin
    pend[4] = ier[ufs_pkg::IE_LINE] && (lsrSticky & ufs_pkg::LS_CLEAR_MASK) != 8'h00;
    pend[3] = ier[ufs_pkg::IE_RXDATA] && rxCount >= rxTrig;
    pend[2] = ier[ufs_pkg::IE_RXDATA] && timeoutP;
    pend[1] = ier[ufs_pkg::IE_TX] && txEmpty;
    pend[0] = ier[ufs_pkg::IE_MODEM] && ctsChanged;
    nPend = 3'(pend[4]) + 3'(pend[3]) + 3'(pend[2]) + 3'(pend[1]) + 3'(pend[0]);
    if (pend[4]) begin
      iirId = ufs_pkg::IRQ_ID_RX_LINE_STATUS;
    end else if (pend[3]) begin
      iirId = ufs_pkg::IRQ_ID_RX_DATA_AVAILABLE;
    end else if (pend[2]) begin
      iirId = ufs_pkg::IRQ_ID_CHAR_TIMEOUT;
    end else if (pend[1]) begin
      iirId = ufs_pkg::IRQ_ID_TX_FIFO_EMPTY;
    end else begin
      iirId = ufs_pkg::IRQ_ID_MODEM_STATUS;
    end
  end

  // ==========================================================
  // apb decode and register update
  logic [31:0] rdVal, next_prdata;
  logic [9:0]  next_ctrl;
  logic [3:0]  next_ier;
  logic [15:0] next_baudDiv;
  logic [7:0]  next_lsrSticky, next_lsrMask;
  logic        next_ctsChanged, next_msMask;
  assign setup    = psel && !penable;
  assign rdAccess = psel && penable && !pwrite;
  assign wrAccess = psel && penable && pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !addrOk;

  always_comb begin
    addrOk = 1'b1;
    if (paddr == ufs_pkg::A_DATA) begin
      rdVal = {24'h0, rxHead};
    end else if (paddr == ufs_pkg::A_CTRL) begin
      rdVal = {22'h0, ctrl};
    end else if (paddr == ufs_pkg::A_FLUSH) begin
      rdVal = 32'h0;
    end else if (paddr == ufs_pkg::A_LSR) begin
      rdVal = {24'h0, lsrVal};
    end else if (paddr == ufs_pkg::A_MSR) begin
      rdVal = {24'h0, msrVal};
    end else if (paddr == ufs_pkg::A_IIR) begin
      rdVal = {28'h0, iirId, nPend <= 3'h1};
    end else if (paddr == ufs_pkg::A_LEVEL) begin
      rdVal = {19'h0, txCount, 3'h0, rxCount};
    end else if (paddr == ufs_pkg::A_IER) begin
      rdVal = {28'h0, ier};
    end else if (paddr == ufs_pkg::A_BAUD) begin
      rdVal = {16'h0, baudDiv};
    end else begin
      rdVal  = 32'h0;
      addrOk = 1'b0;
    end
  end

  always_comb begin
    next_prdata     = setup && !pwrite ? rdVal : prdata;
    next_lsrMask    = setup ? lsrSticky & ufs_pkg::LS_CLEAR_MASK : lsrMask;
    next_msMask     = setup ? ctsChanged : msMask;
    next_ctrl       = ctrl;
    next_ier        = ier;
    next_baudDiv    = baudDiv;
    txPush          = wrAccess && paddr == ufs_pkg::A_DATA;
    txFlush         = wrAccess && paddr == ufs_pkg::A_FLUSH && pwdata[ufs_pkg::F_TX];
    rxFlush         = wrAccess && paddr == ufs_pkg::A_FLUSH && pwdata[ufs_pkg::F_RX];
    next_lsrSticky  = lsrSticky;
    next_ctsChanged = ctsChanged;
    if (wrAccess && paddr == ufs_pkg::A_CTRL) begin
      next_ctrl = pwdata[9:0];
    end
    if (wrAccess && paddr == ufs_pkg::A_IER) begin
      next_ier = pwdata[3:0];
    end
    if (wrAccess && paddr == ufs_pkg::A_BAUD && pwdata[15:0] != 16'h0000) begin
      next_baudDiv = pwdata[15:0];
    end
    if (wrAccess && paddr == ufs_pkg::A_FLUSH) begin
      next_ctrl[ufs_pkg::C_TRIG +: 2] = 2'h0;
    end
    // only bits seen by this read are cleared, so a new event is kept
    if (rdAccess && paddr == ufs_pkg::A_LSR) begin
      next_lsrSticky = lsrSticky & ~lsrMask;
    end
    if (rdAccess && paddr == ufs_pkg::A_MSR && msMask) begin
      next_ctsChanged = 1'b0;
    end
    next_lsrSticky  = next_lsrSticky | rxEv;
    next_ctsChanged = next_ctsChanged | (ctsSync != ctsLast);
    // summary follows its flags, so a flag landing mid-read keeps it set
    next_lsrSticky[ufs_pkg::LS_ERR] = next_lsrSticky[ufs_pkg::LS_PE]
      || next_lsrSticky[ufs_pkg::LS_FE] || next_lsrSticky[ufs_pkg::LS_BI];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata     <= 32'h0;
      ctrl       <= ufs_pkg::CTRL_RESET;
      ier        <= 4'h0;
      baudDiv    <= ufs_pkg::DIV_RESET;
      lsrSticky  <= 8'h00;
      lsrMask    <= 8'h00;
      ctsChanged <= 1'b0;
      msMask     <= 1'b0;
      rts_n      <= 1'b1;
    end else begin
      prdata     <= next_prdata;
      ctrl       <= next_ctrl;
      ier        <= next_ier;
      baudDiv    <= next_baudDiv;
      lsrSticky  <= next_lsrSticky;
      lsrMask    <= next_lsrMask;
      ctsChanged <= next_ctsChanged;
      msMask     <= next_msMask;
      if (ctrl[ufs_pkg::C_ARTS]) begin
        rts_n <= rxCount >= ufs_pkg::RTS_LVL[ctrl[ufs_pkg::C_RLVL +: 2]];
      end else begin
        rts_n <= !ctrl[ufs_pkg::C_RTS];
      end
    end
  end

  // ==========================================================
  // transmitter
  logic [7:0] txShift, next_txShift;
  logic [2:0] txIdx, next_txIdx;
  logic       txPar, next_txPar, next_txd, txGo;
  ufs_pkg::ufs_tx_e next_txState;
  // cts gating applies only before a character starts, never mid-frame
  assign txGo = !txEmpty && (!ctrl[ufs_pkg::C_ACTS] || ctsOn);

  always_comb begin
    next_txState = txState;
    next_txShift = txShift;
    next_txIdx   = txIdx;
    next_txPar   = txPar;
    next_txd     = txd;
    txPop        = 1'b0;
    if (ctrl[ufs_pkg::C_BREAK]) begin
      next_txState = ufs_pkg::TX_IDLE;
      next_txd     = 1'b0;
    end else begin
      case (txState)
        ufs_pkg::TX_IDLE: begin
          next_txd = 1'b1;
          if (txGo) begin
            txPop        = 1'b1;
            next_txShift = txHead;
            next_txState = ufs_pkg::TX_START;
          end
        end
        ufs_pkg::TX_START: if (bitTick) begin
          next_txd     = 1'b0;
          next_txIdx   = 3'h0;
          next_txPar   = 1'b0;
          next_txState = ufs_pkg::TX_DATA;
        end
        ufs_pkg::TX_DATA: if (bitTick) begin
          next_txd     = txShift[0];
          next_txPar   = txPar ^ txShift[0];
          next_txShift = {1'b0, txShift[7:1]};
          next_txIdx   = txIdx + 3'h1;
          if (txIdx == 3'h7) begin
            next_txState = ctrl[ufs_pkg::C_PAREN] ? ufs_pkg::TX_PAR : ufs_pkg::TX_STOP;
          end
        end
        ufs_pkg::TX_PAR: if (bitTick) begin
          next_txd     = ctrl[ufs_pkg::C_EVEN] ? txPar : !txPar;
          next_txState = ufs_pkg::TX_STOP;
        end
        ufs_pkg::TX_STOP: if (bitTick) begin
          next_txd     = 1'b1;
          next_txState = ufs_pkg::TX_END;
        end
        default: if (bitTick) begin
          next_txState = ufs_pkg::TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txState <= ufs_pkg::TX_IDLE;
      txShift <= 8'h00;
      txIdx   <= 3'h0;
      txPar   <= 1'b0;
      txd     <= 1'b1;
    end else begin
      txState <= next_txState;
      txShift <= next_txShift;
      txIdx   <= next_txIdx;
      txPar   <= next_txPar;
      txd     <= next_txd;
    end
  end

  // ==========================================================
  // receiver
  logic [15:0] rxCnt, next_rxCnt;
  logic [2:0]  rxIdx, next_rxIdx;
  logic [7:0]  next_rxShift, toCnt, next_toCnt;
  logic        rxPar, next_rxPar, rxZero, next_rxZero, rxPBad, next_rxPBad;
  ufs_pkg::ufs_rx_e next_rxState;

  always_comb begin
    next_rxState = rxState;
    next_rxCnt   = rxCnt - 16'h0001;
    next_rxShift = rxShift;
    next_rxIdx   = rxIdx;
    next_rxPar   = rxPar;
    next_rxZero  = rxZero;
    next_rxPBad  = rxPBad;
    {setOe, setPe, setFe, setBi, rxPush} = 5'h00;
    case (rxState)
      ufs_pkg::RX_IDLE: if (!rxdSync) begin
        next_rxCnt   = baudDiv >> 1;
        next_rxState = ufs_pkg::RX_START;
      end
      ufs_pkg::RX_START: if (rxCnt == 16'h0000) begin
        next_rxCnt   = baudDiv - 16'h0001;
        next_rxIdx   = 3'h0;
        next_rxPar   = 1'b0;
        next_rxZero  = 1'b1;
        next_rxPBad  = 1'b0;
        next_rxState = rxdSync ? ufs_pkg::RX_IDLE : ufs_pkg::RX_DATA;
      end
      ufs_pkg::RX_DATA: if (rxCnt == 16'h0000) begin
        next_rxCnt   = baudDiv - 16'h0001;
        next_rxShift = {rxdSync, rxShift[7:1]};
        next_rxPar   = rxPar ^ rxdSync;
        next_rxZero  = rxZero && !rxdSync;
        next_rxIdx   = rxIdx + 3'h1;
        if (rxIdx == 3'h7) begin
          next_rxState = ctrl[ufs_pkg::C_PAREN] ? ufs_pkg::RX_PAR : ufs_pkg::RX_STOP;
        end
      end
      ufs_pkg::RX_PAR: if (rxCnt == 16'h0000) begin
        next_rxCnt   = baudDiv - 16'h0001;
        next_rxZero  = rxZero && !rxdSync;
        next_rxPBad  = (rxPar ^ rxdSync) != !ctrl[ufs_pkg::C_EVEN];
        next_rxState = ufs_pkg::RX_STOP;
      end
      ufs_pkg::RX_STOP: if (rxCnt == 16'h0000) begin
        next_rxState = rxdSync ? ufs_pkg::RX_IDLE : ufs_pkg::RX_HOLD;
        if (rxZero && !rxdSync) begin
          setBi = 1'b1;
        end else if (rxCount == ufs_pkg::FIFO_DEPTH) begin
          setOe = 1'b1;
        end else begin
          rxPush = 1'b1;
          setFe  = !rxdSync;
          setPe  = rxPBad;
        end
      end
      default: if (rxdSync) begin
        next_rxState = ufs_pkg::RX_IDLE;
      end
    endcase
    rxEv         = 8'h00;
    rxEv[ufs_pkg::LS_OE]  = setOe;
    rxEv[ufs_pkg::LS_PE]  = setPe;
    rxEv[ufs_pkg::LS_FE]  = setFe;
    rxEv[ufs_pkg::LS_BI]  = setBi;
    rxEv[ufs_pkg::LS_ERR] = setPe || setFe || setBi;
    // character timeout: about four idle frames with data waiting
    next_toCnt = toCnt;
    if (rxCount == 5'h00 || rxPush || (rdAccess && paddr == ufs_pkg::A_DATA)) begin
      next_toCnt = 8'h00;
    end else if (bitTick && rxState == ufs_pkg::RX_IDLE && !timeoutP) begin
      next_toCnt = toCnt + 8'h01;
    end
  end
  assign timeoutP = toCnt >= ufs_pkg::TIMEOUT_BITS;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState <= ufs_pkg::RX_IDLE;
      rxCnt   <= 16'h0000;
      rxShift <= 8'h00;
      rxIdx   <= 3'h0;
      rxPar   <= 1'b0;
      rxZero  <= 1'b0;
      rxPBad  <= 1'b0;
      toCnt   <= 8'h00;
    end else begin
      rxState <= next_rxState;
      rxCnt   <= next_rxCnt;
      rxShift <= next_rxShift;
      rxIdx   <= next_rxIdx;
      rxPar   <= next_rxPar;
      rxZero  <= next_rxZero;
      rxPBad  <= next_rxPBad;
      toCnt   <= next_toCnt;
    end
  end

  // ==========================================================
  // checks
  sequence lsrReadS;
    rdAccess && paddr == ufs_pkg::A_LSR && rxEv == 8'h00 && $past(rxEv) == 8'h00;
  endsequence
  sequence ctsBlockS;
    ctrl[ufs_pkg::C_ACTS] && !ctsOn && txState == ufs_pkg::TX_IDLE;
  endsequence
  break_low_a: assert property (ctrl[ufs_pkg::C_BREAK] |=> !txd && txShiftEmpty)
    else $error("break did not hold line low");
  tx_start_a: assert property (!ctrl[ufs_pkg::C_BREAK] && txShiftEmpty && txGo
    |=> txState == ufs_pkg::TX_START && txCount == $past(txCount) - 5'h01)
    else $error("waiting byte not started");
  flush_trig_a: assert property (txFlush |=> txCount == 5'h00 && rxTrig == 5'h01)
    else $error("flush did not empty fifo or reset trigger");
  lsr_clear_a: assert property (setup && !pwrite && paddr == ufs_pkg::A_LSR ##1 lsrReadS
    |=> (lsrSticky & ufs_pkg::LS_CLEAR_MASK) == 8'h00)
    else $error("line status errors survived read");
  err_sum_a: assert property (lsrSticky[ufs_pkg::LS_ERR] == (lsrSticky[ufs_pkg::LS_PE]
    || lsrSticky[ufs_pkg::LS_FE] || lsrSticky[ufs_pkg::LS_BI]))
    else $error("error summary mismatch");
  overrun_a: assert property (rxState == ufs_pkg::RX_STOP && rxCnt == 16'h0000 && rxdSync
    && rxCount == ufs_pkg::FIFO_DEPTH |=> lsrSticky[ufs_pkg::LS_OE] && rxCount == 5'h10)
    else $error("overrun not flagged");
  cts_hold_a: assert property (ctsBlockS && !txFlush |=> txShiftEmpty
    && txCount >= $past(txCount))
    else $error("sent while cts deasserted");
  line_first_a: assert property (pend[4] |-> iirId == 3'h3 && (nPend == 3'h1) == (pend[3:0]
    == 4'h0))
    else $error("line status not reported first");
  auto_rts_a: assert property (ctrl[ufs_pkg::C_ARTS] && $stable(rxCount) && $stable(ctrl) |->
    rts_n == (rxCount >= ufs_pkg::RTS_LVL[ctrl[ufs_pkg::C_RLVL +: 2]]))
    else $error("auto rts level wrong");
endmodule

`default_nettype wire
